// ===== rtl/ufsc_defines.vh
// Constants for the FIFO control shadow block of the serial port.
// Assumes a 32-bit byte address, 32-bit data and a 16-entry FIFO pair.
`ifndef UFSC_DEFINES_VH
`define UFSC_DEFINES_VH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define UFSC_ADDR_SFE      32'h50020198
`define UFSC_ADDR_SRT      32'h5002019c
`define UFSC_ADDR_STET     32'h500201a0
`define UFSC_ADDR_FCW      32'h500201e0
`define UFSC_ADDR_CTRL     32'h500201e4
`define UFSC_ADDR_ISTAT    32'h500201e8
`define UFSC_ADDR_IMASK    32'h500201ec
`define UFSC_ADDR_LEVEL    32'h500201f0

// ****************************************************************
// Field positions of the fifo control word.
// ****************************************************************
`define UFSC_FCW_EN        0
`define UFSC_FCW_RXRST     1
`define UFSC_FCW_TXRST     2
`define UFSC_FCW_DMA       3
`define UFSC_FCW_TXT_LO    4
`define UFSC_FCW_RXT_LO    6

// Control register: bit 0 threshold mode, bit 1 DMA mode mirror.
`define UFSC_CTRL_THR      0
`define UFSC_CTRL_DMA      1

// Interrupt status bits.
`define UFSC_IRQ_RXAV      0
`define UFSC_IRQ_TXE       1
`define UFSC_IRQ_FLUSH     2
`define UFSC_IRQ_W         3

// ****************************************************************
// Reset values and FIFO geometry.
// ****************************************************************
`define UFSC_RST_FCW       8'h00
`define UFSC_RST_CTRL      2'h0
`define UFSC_RST_IRQ       3'h0
`define UFSC_CNT_W         5

// Receive trigger levels, in stored characters.
`define UFSC_RXL_0         5'h01
`define UFSC_RXL_1         5'h04
`define UFSC_RXL_2         5'h08
`define UFSC_RXL_3         5'h0e

// Transmit empty thresholds, in characters left.
`define UFSC_TXL_0         5'h00
`define UFSC_TXL_1         5'h02
`define UFSC_TXL_2         5'h04
`define UFSC_TXL_3         5'h08

`endif

// ===== rtl/ufsc_level_cmp.v
// Registered fill-level comparator with a two-bit level select.
// Assumes the count comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ufsc_level_cmp #(
	parameter       AT_LEAST = 1,     // 1: count >= level, 0: count <= level
	parameter [4:0] LVL0     = 5'h00, // Level for code 00.
	parameter [4:0] LVL1     = 5'h00, // Level for code 01.
	parameter [4:0] LVL2     = 5'h00, // Level for code 10.
	parameter [4:0] LVL3     = 5'h00  // Level for code 11.
) (
	input  wire       mclk,   // System clock.
	input  wire       arst_n, // Asynchronous reset, active low.
	input  wire [1:0] sel,    // Level select code.
	input  wire [4:0] count,  // Current fill count.
	output reg        hit_r   // Registered comparison result.
);

	reg  [4:0] level;
	wire       hit_nxt;

	// Decode the select code into a character count.
	always @* begin
		case (sel)
			2'h0:    level = LVL0;
			2'h1:    level = LVL1;
			2'h2:    level = LVL2;
			default: level = LVL3;
		endcase
	end

	// Direction is fixed per instance, so only one compare survives.
	assign hit_nxt = (AT_LEAST != 0) ? (count >= level) : (count <= level);

	// Register the result so downstream flags see a clean level.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= hit_nxt;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/ufsc_top.v
// FIFO control shadow registers of a 16550-style serial port, with the
// trigger logic they steer and a small sticky interrupt block.
// Assumes FIFO counts arrive from logic on mclk and software drives a
// simple strobe register port without wait states.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ufsc_defines.vh"

// Behaviour
// R01: FIFO enable shadow reads and writes control bit 0 only.
// R02: FIFOs are used only while the enable bit is set.
// R03: Enable falling from one to zero resets both FIFO controllers.
// R04: Receive trigger shadow reads and writes control bits 7:6 only.
// R05: Received-data interrupt rises when receive fill reaches trigger.
// R06: Receive codes mean one char, quarter, half, two short of full.
// R07: In DMA mode one, receive trigger decides the low receive request.
// R08: Transmit trigger shadow reads and writes control bits 5:4 only.
// R09: In threshold mode, transmit interrupt at empty or two characters.
// R10: Transmit codes 10 and 11 are quarter and half; shadows reset zero.
module ufsc_top (
	input  wire        mclk,          // System clock, 100 MHz.
	input  wire        arst_n,        // Asynchronous reset, active low.
	input  wire [31:0] addr,          // Register byte address.
	input  wire [31:0] wdata,         // Register write data.
	input  wire        wr,            // Write strobe, one cycle.
	input  wire        rd,            // Read strobe, one cycle.
	output reg  [31:0] rdata_r,       // Read data, cycle after rd.
	input  wire [4:0]  rx_count,      // Receive queue fill count.
	input  wire [4:0]  tx_count,      // Transmit queue fill count.
	output wire        fifo_en,       // Queues in use.
	output reg         rx_flush_r,    // Receive queue controller reset.
	output reg         tx_flush_r,    // Transmit queue controller reset.
	output reg         rx_avail_r,    // Received data available level.
	output reg         tx_holding_empty_irq_r, // Transmit holding empty.
	output reg         dma_rx_req_n_r, // Receive DMA request, active low.
	output wire        irq            // Interrupt, high while pending.
);

	// ****************************************************************
	// Register state.
	// ****************************************************************
	reg  [7:0]  fifo_control_word_r;
	reg  [7:0]  fifo_control_word_nxt;
	reg  [1:0]  ctrl_r;
	reg  [`UFSC_IRQ_W-1:0] istat_r;
	reg  [`UFSC_IRQ_W-1:0] istat_nxt;
	reg  [`UFSC_IRQ_W-1:0] imask_r;
	reg         rx_avail_d_r;
	reg         txe_d_r;
	reg  [31:0] rdata_nxt;

	wire        en_now;
	wire [1:0]  rx_level_mirror;
	wire [1:0]  tx_level_mirror;
	wire        thr_mode;
	wire        dma_mode;
	wire        rx_hit;
	wire        tx_hit;
	wire        en_fall;
	wire        rx_flush_nxt;
	wire        tx_flush_nxt;
	wire        rx_avail_nxt;
	wire        txe_nxt;
	wire        dma_req_nxt;
	wire [`UFSC_IRQ_W-1:0] ev;
	wire [`UFSC_IRQ_W-1:0] clr;

	assign en_now          = fifo_control_word_r[`UFSC_FCW_EN];
	assign rx_level_mirror = fifo_control_word_r[`UFSC_FCW_RXT_LO+1:
	                                             `UFSC_FCW_RXT_LO];
	assign tx_level_mirror = fifo_control_word_r[`UFSC_FCW_TXT_LO+1:
	                                             `UFSC_FCW_TXT_LO];
	assign thr_mode        = ctrl_r[`UFSC_CTRL_THR];
	assign dma_mode        = fifo_control_word_r[`UFSC_FCW_DMA];

	// ****************************************************************
	// Control word update from the full word and the shadows.
	// ****************************************************************

	// Each shadow write touches only its own field, so software never
	// needs a read-modify-write of the write-only control word.
	always @* begin
		fifo_control_word_nxt = fifo_control_word_r;
		// Reset request bits are self-clearing one-cycle commands.
		fifo_control_word_nxt[`UFSC_FCW_RXRST] = 1'b0;
		fifo_control_word_nxt[`UFSC_FCW_TXRST] = 1'b0;
		if (wr) begin
			case (addr)
				`UFSC_ADDR_FCW: begin
					fifo_control_word_nxt = wdata[7:0];
				end
				`UFSC_ADDR_SFE: begin
					fifo_control_word_nxt[`UFSC_FCW_EN] = wdata[0]; // R01
				end
				`UFSC_ADDR_SRT: begin
					fifo_control_word_nxt[`UFSC_FCW_RXT_LO+1:
					                      `UFSC_FCW_RXT_LO] = wdata[1:0]; // R04
				end
				`UFSC_ADDR_STET: begin
					fifo_control_word_nxt[`UFSC_FCW_TXT_LO+1:
					                      `UFSC_FCW_TXT_LO] = wdata[1:0]; // R08
				end
				`UFSC_ADDR_CTRL: begin
					fifo_control_word_nxt[`UFSC_FCW_DMA] = wdata[`UFSC_CTRL_DMA];
				end
				default: begin
					fifo_control_word_nxt = fifo_control_word_nxt;
				end
			endcase
		end
	end

	// Shadows and control word share one flop set, so all views agree.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_control_word_r <= `UFSC_RST_FCW; // R10
		end else begin
			fifo_control_word_r <= fifo_control_word_nxt;
		end
	end

	// Threshold mode lives in the control register; DMA mode mirrors
	// control word bit 3, which reads and logic use; ctrl_r bit 1 keeps an unused copy.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `UFSC_RST_CTRL;
		end else if (wr && (addr == `UFSC_ADDR_CTRL)) begin
			ctrl_r <= wdata[1:0];
		end
	end

	// ****************************************************************
	// Queue controller resets.
	// ****************************************************************

	// Disabling the queues after use flushes both controllers; an explicit
	// reset bit written through the full control word flushes only its own.
	assign en_fall      = en_now && !fifo_control_word_nxt[`UFSC_FCW_EN]; // R03
	assign rx_flush_nxt = en_fall ||
	                      fifo_control_word_nxt[`UFSC_FCW_RXRST];
	assign tx_flush_nxt = en_fall ||
	                      fifo_control_word_nxt[`UFSC_FCW_TXRST];

	// Flushes are registered one-cycle pulses for the queue logic.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_flush_r <= 1'b0;
			tx_flush_r <= 1'b0;
		end else begin
			rx_flush_r <= rx_flush_nxt; // R03
			tx_flush_r <= tx_flush_nxt; // R03
		end
	end

	assign fifo_en = en_now; // R02

	// ****************************************************************
	// Trigger comparators.
	// ****************************************************************

	// Receive trigger: reached when the fill is at least the level.
	ufsc_level_cmp #(
		.AT_LEAST (1),
		.LVL0     (`UFSC_RXL_0),
		.LVL1     (`UFSC_RXL_1),
		.LVL2     (`UFSC_RXL_2),
		.LVL3     (`UFSC_RXL_3)
	) u_rx_cmp (
		.mclk   (mclk),
		.arst_n (arst_n),
		.sel    (rx_level_mirror), // R06
		.count  (rx_count),
		.hit_r  (rx_hit)
	);

	// Transmit threshold: reached when no more than the level remains.
	ufsc_level_cmp #(
		.AT_LEAST (0),
		.LVL0     (`UFSC_TXL_0),
		.LVL1     (`UFSC_TXL_1),
		.LVL2     (`UFSC_TXL_2),
		.LVL3     (`UFSC_TXL_3)
	) u_tx_cmp (
		.mclk   (mclk),
		.arst_n (arst_n),
		.sel    (tx_level_mirror), // R10
		.count  (tx_count),
		.hit_r  (tx_hit)
	);

	// ****************************************************************
	// Data available, holding empty and DMA request.
	// ****************************************************************

	// Without queues a single held character is enough, so the trigger
	// only applies while queues are enabled.
	assign rx_avail_nxt = en_now ? rx_hit : (rx_count != 5'h00); // R05

	// Threshold mode is honoured only with queues on; otherwise the
	// plain empty condition drives the holding-empty flag.
	assign txe_nxt = (thr_mode && en_now) ? tx_hit // R09
	                                      : (tx_count == 5'h00);

	// With queues on, mode one waits for the trigger; mode zero or queues off asks per character.
	assign dma_req_nxt = (dma_mode && en_now) ? rx_hit // R07
	                                          : (rx_count != 5'h00);

	// All three outputs are registered to keep them glitch free.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_avail_r             <= 1'b0;
			tx_holding_empty_irq_r <= 1'b0;
			dma_rx_req_n_r         <= 1'b1;
		end else begin
			rx_avail_r             <= rx_avail_nxt;
			tx_holding_empty_irq_r <= txe_nxt;
			dma_rx_req_n_r         <= !dma_req_nxt;
		end
	end

	// ****************************************************************
	// Sticky interrupt status.
	// ****************************************************************

	// Edge history so each rise of a level counts as one event.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_avail_d_r <= 1'b0;
			txe_d_r      <= 1'b0;
		end else begin
			rx_avail_d_r <= rx_avail_r;
			txe_d_r      <= tx_holding_empty_irq_r;
		end
	end

	assign ev[`UFSC_IRQ_RXAV]  = rx_avail_r && !rx_avail_d_r;
	assign ev[`UFSC_IRQ_TXE]   = tx_holding_empty_irq_r && !txe_d_r;
	assign ev[`UFSC_IRQ_FLUSH] = rx_flush_r || tx_flush_r;
	assign clr = (wr && (addr == `UFSC_ADDR_ISTAT)) ?
	             wdata[`UFSC_IRQ_W-1:0] : {`UFSC_IRQ_W{1'b0}};

	// A new event wins over a write-one-to-clear in the same cycle.
	always @* begin
		istat_nxt = (istat_r & ~clr) | ev;
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			istat_r <= `UFSC_RST_IRQ;
			imask_r <= `UFSC_RST_IRQ;
		end else begin
			istat_r <= istat_nxt;
			if (wr && (addr == `UFSC_ADDR_IMASK)) begin
				imask_r <= wdata[`UFSC_IRQ_W-1:0];
			end
		end
	end

	assign irq = |(istat_r & imask_r);

	// ****************************************************************
	// Read path.
	// ****************************************************************

	// The full control word is write-only and reads as zero, as do
	// unmapped addresses; upper shadow bits are always zero.
	always @* begin
		rdata_nxt = 32'h00000000;
		case (addr)
			`UFSC_ADDR_SFE:   rdata_nxt[0]   = en_now;          // R01
			`UFSC_ADDR_SRT:   rdata_nxt[1:0] = rx_level_mirror; // R04
			`UFSC_ADDR_STET:  rdata_nxt[1:0] = tx_level_mirror; // R08
			`UFSC_ADDR_CTRL: begin
				rdata_nxt[`UFSC_CTRL_THR] = thr_mode;
				rdata_nxt[`UFSC_CTRL_DMA] = dma_mode;
			end
			`UFSC_ADDR_ISTAT: rdata_nxt[`UFSC_IRQ_W-1:0] = istat_r;
			`UFSC_ADDR_IMASK: rdata_nxt[`UFSC_IRQ_W-1:0] = imask_r;
			`UFSC_ADDR_LEVEL: begin
				rdata_nxt[4:0]   = rx_count;
				rdata_nxt[12:8]  = tx_count;
				rdata_nxt[16]    = rx_avail_r;
				rdata_nxt[17]    = tx_holding_empty_irq_r;
			end
			default:          rdata_nxt = 32'h00000000;
		endcase
	end

	// Data stand only in the cycle after the read strobe.
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h00000000;
		end else if (rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h00000000;
		end
	end

endmodule

`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the FIFO control shadow block.
// Assumes the block top, its header and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ufsc_defines.vh"

// ********
// Bench
// ********
module tb_top;
	logic        mclk, arst_n, wr, rd;
	logic [31:0] addr, wdata, rv, wdv;
	logic [4:0]  rx_count, tx_count;
	wire  [31:0] rdata_r;
	wire         fifo_en, rx_flush_r, tx_flush_r, rx_avail_r;
	wire         tx_holding_empty_irq_r, dma_rx_req_n_r, irq;
	int          n_errors, comparisons, i, j, c, k, r;
	int          rx_lvl[4] = '{1, 4, 8, 14};
	int          tx_lvl[4] = '{0, 2, 4, 8};
	logic [31:0] sh[3] = '{`UFSC_ADDR_SFE, `UFSC_ADDR_SRT, `UFSC_ADDR_STET};
	logic [31:0] msk[3] = '{32'h1, 32'h3, 32'h3};
	logic [31:0] mdl[3];

	ufsc_top u_ufsc_top (.mclk(mclk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
		.rx_count(rx_count), .tx_count(tx_count), .fifo_en(fifo_en),
		.rx_flush_r(rx_flush_r), .tx_flush_r(tx_flush_r),
		.rx_avail_r(rx_avail_r), .irq(irq),
		.tx_holding_empty_irq_r(tx_holding_empty_irq_r),
		.dma_rx_req_n_r(dma_rx_req_n_r));

	// Free-running 100 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Strobes last one cycle; the edge that ends the task takes them.
	task automatic wr_reg(logic [31:0] a, logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(logic [31:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		v = rdata_r;
	endtask

	// Levels trail a change by two registers and irq by three, so wait past all.
	task automatic settle();
		repeat (4) @(posedge mclk);
		#1;
	endtask

	task automatic set_counts(logic [4:0] rc, logic [4:0] tc);
		@(posedge mclk);
		rx_count <= rc;
		tx_count <= tc;
		settle();
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#300000;
		n_errors++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		{addr, wdata, wr, rd, rx_count, tx_count, arst_n} = '0;
		n_errors = 0;
		comparisons = 0;
		k = $urandom(32'hff14b539);
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;
		for (i = 0; i < 3; i++) begin
			rd_reg(sh[i], rv);
			check("shadow_reset", rv, 32'h0);
		end
		check("dma_reset", dma_rx_req_n_r, 1'b1);
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			wr_reg(sh[i], 32'hffffffff);
			rd_reg(sh[i], rv);
			check("shadow_mask", rv, msk[i]);
		end
		mdl = msk;
		for (k = 0; k < 9; k++) begin
			wdv = $urandom;
			wr_reg(sh[k % 3], wdv);
			mdl[k % 3] = wdv & msk[k % 3];
			for (i = 0; i < 3; i++) begin
				rd_reg(sh[i], rv);
				check("shadow_field", rv, mdl[i]);
			end
		end
		wr_reg(`UFSC_ADDR_FCW, 32'h000000d1);
		rd_reg(`UFSC_ADDR_SFE, rv);
		check("fcw_en", rv, 32'h1);
		rd_reg(`UFSC_ADDR_SRT, rv);
		check("fcw_rx", rv, 32'h3);
		rd_reg(`UFSC_ADDR_STET, rv);
		check("fcw_tx", rv, 32'h1);
		rd_reg(`UFSC_ADDR_FCW, rv);
		check("fcw_read", rv, 32'h0);
		rd_reg(32'h50020300, rv);
		check("unmapped", rv, 32'h0);
		$display("test shadows done");
		// Receive levels at both sides of each trigger, DMA mode one.
		wr_reg(`UFSC_ADDR_CTRL, 32'h2);
		rd_reg(`UFSC_ADDR_CTRL, rv);
		check("ctrl", rv, 32'h2);
		for (c = 0; c < 4; c++) begin
			wr_reg(`UFSC_ADDR_SRT, c);
			for (j = 0; j < 4; j++) begin
				r = (j == 0) ? rx_lvl[c] - 1 : (j == 1) ? rx_lvl[c] :
					(j == 2) ? 16 : $urandom_range(16, 0);
				set_counts(5'(r), 5'($urandom_range(16, 0)));
				check("rx_avail", rx_avail_r, r >= rx_lvl[c]);
				check("dma_req", dma_rx_req_n_r, r < rx_lvl[c]);
			end
		end
		wr_reg(`UFSC_ADDR_CTRL, 32'h0);
		set_counts(5'h01, 5'h00);
		check("rx_mode0", rx_avail_r, 1'b0);
		check("dma_mode0", dma_rx_req_n_r, 1'b0);
		$display("test receive done");
		// Transmit thresholds in threshold mode.
		wr_reg(`UFSC_ADDR_CTRL, 32'h1);
		for (c = 0; c < 4; c++) begin
			wr_reg(`UFSC_ADDR_STET, c);
			for (j = 0; j < 4; j++) begin
				r = (j == 0) ? tx_lvl[c] : (j == 1) ? tx_lvl[c] + 1 :
					(j == 2) ? 16 : $urandom_range(16, 0);
				set_counts(5'h00, 5'(r));
				check("tx_empty", tx_holding_empty_irq_r, r <= tx_lvl[c]);
			end
		end
		wr_reg(`UFSC_ADDR_CTRL, 32'h0);
		$display("test transmit done");
		// Clearing the enable pulses both controller resets once.
		wr_reg(`UFSC_ADDR_SFE, 32'h0);
		#1;
		check("flush", {rx_flush_r, tx_flush_r}, 2'b11);
		@(posedge mclk);
		#1;
		check("flush_end", {rx_flush_r, tx_flush_r}, 2'b00);
		check("fifo_off", fifo_en, 1'b0);
		set_counts(5'h03, 5'h01);
		check("rx_off", rx_avail_r, 1'b1);
		check("tx_empty_off", tx_holding_empty_irq_r, 1'b0);
		rd_reg(`UFSC_ADDR_LEVEL, rv);
		check("level", rv, 32'h00010103);
		// A transmit reset bit in the full word pulses only its flush.
		wr_reg(`UFSC_ADDR_FCW, 32'h00000004);
		#1;
		check("fcw_txrst", {rx_flush_r, tx_flush_r}, 2'b01);
		$display("test disable done");
		// Sticky status, mask and write-one clear.
		rd_reg(`UFSC_ADDR_ISTAT, rv);
		check("flush_status", rv & 32'h4, 32'h4);
		wr_reg(`UFSC_ADDR_ISTAT, 32'h7);
		set_counts(5'h00, 5'h01);
		wr_reg(`UFSC_ADDR_IMASK, 32'h1);
		settle();
		check("irq_idle", irq, 1'b0);
		set_counts(5'h02, 5'h01);
		check("irq_set", irq, 1'b1);
		rd_reg(`UFSC_ADDR_ISTAT, rv);
		check("status", rv & 32'h1, 32'h1);
		wr_reg(`UFSC_ADDR_IMASK, 32'h0);
		settle();
		check("irq_masked", irq, 1'b0);
		wr_reg(`UFSC_ADDR_IMASK, 32'h1);
		wr_reg(`UFSC_ADDR_ISTAT, 32'h1);
		settle();
		check("irq_clear", irq, 1'b0);
		$display("test interrupt done");
		print_verdict();
	end
endmodule
`default_nettype wire

// ===== test/ufsc_top_sva.sv
// Port checks for the FIFO control shadow block.
// Assumes the block top and its defines header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ufsc_defines.vh"

// ********
// Checker
// ********
module ufsc_top_sva (
	input wire logic        mclk,     // Clock.
	input wire logic        arst_n,   // Reset, active low.
	input wire logic [31:0] addr,     // Address.
	input wire logic [31:0] wdata,    // Write data.
	input wire logic        wr,       // Write strobe.
	input wire logic        rd,       // Read strobe.
	input wire logic [31:0] rdata_r,  // Read data.
	input wire logic [4:0]  rx_count, // Receive fill.
	input wire logic [4:0]  tx_count, // Transmit fill.
	input wire logic        fifo_en,  // Queues in use.
	input wire logic        rx_flush_r, // Receive reset.
	input wire logic        tx_flush_r, // Transmit reset.
	input wire logic        rx_avail_r, // Receive data level.
	input wire logic        tx_holding_empty_irq_r, // Transmit empty.
	input wire logic        dma_rx_req_n_r, // Receive request.
	input wire logic        irq       // Interrupt.
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	// Levels are checked only after four quiet samples, which covers
	// the two-stage pipeline after a count or mode change.
	property p_rd_idle;
		!rd |=> rdata_r == 32'h0;
	endproperty
	property p_sfe_read;
		(rd && addr == `UFSC_ADDR_SFE) |=> rdata_r == {31'h0, $past(fifo_en)};
	endproperty
	property p_sfe_write;
		(wr && addr == `UFSC_ADDR_SFE) |=> fifo_en == $past(wdata[0]);
	endproperty
	property p_flush;
		(wr && addr == `UFSC_ADDR_SFE && !wdata[0] && fifo_en)
			|-> ##1 (rx_flush_r && tx_flush_r);
	endproperty
	property p_dis_rx;
		(!fifo_en && $stable(rx_count))[*4] |-> rx_avail_r == (rx_count != 5'h00);
	endproperty
	property p_dis_dma;
		(!fifo_en && $stable(rx_count))[*4]
			|-> dma_rx_req_n_r == (rx_count == 5'h00);
	endproperty
	property p_dis_txe;
		(!fifo_en && $stable(tx_count))[*4]
			|-> tx_holding_empty_irq_r == (tx_count == 5'h00);
	endproperty
	property p_rx_full;
		($stable(rx_count) && rx_count == 5'h10)[*4] |-> rx_avail_r;
	endproperty
	property p_rx_empty;
		($stable(rx_count) && rx_count == 5'h00)[*4]
			|-> !rx_avail_r && dma_rx_req_n_r;
	endproperty
	property p_tx_full;
		($stable(tx_count) && tx_count == 5'h10)[*4] |-> !tx_holding_empty_irq_r;
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_sfe_read: assert property (p_sfe_read) else $error("enable read");
	a_sfe_write: assert property (p_sfe_write) else $error("enable write");
	a_flush: assert property (p_flush) else $error("no flush pulse");
	a_dis_rx: assert property (p_dis_rx) else $error("rx avail off");
	a_dis_dma: assert property (p_dis_dma) else $error("dma req off");
	a_dis_txe: assert property (p_dis_txe) else $error("holding empty off");
	a_rx_full: assert property (p_rx_full) else $error("rx full");
	a_rx_empty: assert property (p_rx_empty) else $error("rx empty");
	a_tx_full: assert property (p_tx_full) else $error("tx full");

	c_flush: cover property (rx_flush_r && tx_flush_r);
	c_irq: cover property ($rose(irq));
	c_dma: cover property (fifo_en && !dma_rx_req_n_r);
endmodule

bind ufsc_top ufsc_top_sva u_sva (.mclk(mclk), .arst_n(arst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .rx_count(rx_count),
	.tx_count(tx_count), .fifo_en(fifo_en), .rx_flush_r(rx_flush_r),
	.tx_flush_r(tx_flush_r), .rx_avail_r(rx_avail_r), .irq(irq),
	.tx_holding_empty_irq_r(tx_holding_empty_irq_r),
	.dma_rx_req_n_r(dma_rx_req_n_r));
`default_nettype wire
